/* File: rtl/sgc_pkg.sv */
// Constants and types shared by the start-up gate controller.
// Assumes a single 100 MHz clock; all intervals are counted in its cycles.
package sgc_pkg;

    // ==========================================================
    // Clock and interval figures
    localparam int CLK_NS       = 10;
    localparam int BLANK_NS     = 240;
    localparam int WIN_NS       = 166;
    localparam int OFF_NS       = 21000;
    localparam int CEASE_NS     = 260000;
    localparam int BURST_GAP_NS = 4000;

    localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
    localparam int WIN_CYC   = (WIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int OFF_CYC   = (OFF_NS + CLK_NS - 1) / CLK_NS;
    localparam int CEASE_CYC = (CEASE_NS + CLK_NS - 1) / CLK_NS;
    // Falling edges closer than this belong to one sleep burst
    localparam int GAP_CYC   = BURST_GAP_NS / CLK_NS;

    // ==========================================================
    // Widths and counts
    localparam int TMR_W  = 16;
    localparam int LFO_W  = 21;
    localparam int GAP_W  = 9;

    localparam logic [4:0]       PULSE_MAX   = 5'h10;
    localparam logic [2:0]       SLEEP_EDGES = 3'h5;
    localparam logic [GAP_W-1:0] GAP_MAX     = GAP_W'(GAP_CYC);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ON,
        ST_OFF
    } sgc_state_t;

endpackage

/* File: rtl/sgc_timer.sv */
// One-shot interval timer used for blanking, window, off-time and cease.
// Assumes start is a single-cycle pulse; a start while running reloads.
module sgc_timer #(
    parameter int          W     = 16,
    parameter int unsigned COUNT = 1
) (
    input  logic clk,
    input  logic nrst,
    input  logic start,
    output logic run,
    output logic done
);

    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic         next_run;
    logic         next_done;

    // ==========================================================
    // Run stays high for exactly COUNT cycles after start
    always_comb begin
        next_cnt  = cnt;
        next_run  = run;
        next_done = 1'b0;
        if (start) begin
            next_run = 1'b1;
            next_cnt = W'(COUNT - 1);
        end else if (run) begin
            if (cnt == '0) begin
                next_run  = 1'b0;
                next_done = 1'b1;
            end else begin
                next_cnt = cnt - W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt  <= '0;
            run  <= 1'b0;
            done <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            run  <= next_run;
            done <= next_done;
        end
    end

endmodule

/* File: rtl/sgc_gate_ctrl.sv */
// Gate-control logic of a primary-side flyback start-up controller.
// Assumes supply comparators, current comparators and the command pin
// arrive as clean levels synchronous to clk; lfo_period comes from the
// resistor-programmed oscillator setting, in clk cycles.
//
// Operation
// R1: Accept external commands only once the supply passes the regulator turn-off level.
// R2: Undervoltage flag uses hysteresis; above upper level internal regulator may gate.
// R3: Below the lower undervoltage level, gate held low and all gating suppressed.
// R4: Overvoltage stops all gating until supply falls below lower hysteresis level.
// R5: Both comparators ignored for the blanking interval at each on-time start.
// R6: Window follows blanking; window comparator trip inside it ends the on-time.
// R7: Comparators ORed into latch reset; reset ends on-time and starts off-time.
// R8: Internal mode: fixed off-time, then latch set and a new on-time starts.
// R9: Low peak reference under internal control, high reference under external control.
// R10: External mode: comparator trip ends on-time until next external on command.
// R11: Start-up allows exactly sixteen pulses per oscillator period, then no gating.
// R12: Oscillator period is set externally and only counted here.
// R13: External run mode disables oscillator burst gating entirely.
// R14: Secondary controller should regulate quickly so external bias persists.
// R15: Command input active low; low requests gate high.
// R16: No command activity for the cease interval returns control to start-up mode.
// R17: Five fast pulses command sleep; gating stops until commands resume or lockout.
// R18: All intervals measured by counters on one clock with parameter terminal counts; the oscillator period count ends at the lfo_period input instead.
module sgc_gate_ctrl #(
    parameter int unsigned CEASE_CYC = sgc_pkg::CEASE_CYC,
    parameter int          LFO_W     = sgc_pkg::LFO_W
) (
    input  logic             clk,
    input  logic             nrst,
    input  logic             vdd_above_uv_hi,
    input  logic             vdd_below_uv_lo,
    input  logic             vdd_above_ov_hi,
    input  logic             vdd_below_ov_lo,
    input  logic             vdd_above_reg_off,
    input  logic             pulse_n,
    input  logic             peak_limit_cmp,
    input  logic             ccm_window_cmp,
    input  logic [LFO_W-1:0] lfo_period,
    output logic             gate,
    output logic             peak_ref_high,
    output logic             ext_mode,
    output logic             sleep_mode
);

    logic                    uv_ok;
    logic                    ov_lock;
    logic                    next_uv_ok;
    logic                    next_ov_lock;
    logic                    gate_ok;
    logic                    pulse_q;
    logic                    next_pulse_q;
    logic                    fall;
    logic                    act;
    logic                    next_ext;
    logic                    next_sleep;
    logic                    next_ref_high;
    logic [2:0]              edge_cnt;
    logic [2:0]              next_edge;
    logic [sgc_pkg::GAP_W-1:0] gap_cnt;
    logic [sgc_pkg::GAP_W-1:0] next_gap;
    sgc_pkg::sgc_state_t     state;
    sgc_pkg::sgc_state_t     next_state;
    logic                    next_gate;
    logic                    on_start;
    logic                    off_start;
    logic                    trip;
    logic [LFO_W-1:0]        lfo_cnt;
    logic [LFO_W-1:0]        next_lfo;
    logic                    lfo_wrap;
    logic [4:0]              pulse_cnt;
    logic [4:0]              next_pcnt;
    logic                    burst_ok;
    logic                    blank_run;
    logic                    blank_done;
    logic                    win_run;
    logic                    win_open;
    logic                    off_run;
    logic                    off_done;
    logic                    cease_done;

    // ==========================================================
    // Interval timers, all on clk
    sgc_timer #(.W(sgc_pkg::TMR_W), .COUNT(sgc_pkg::BLANK_CYC)) u_blank ( // [R18] [R5]
        .clk   (clk),
        .nrst  (nrst),
        .start (on_start),
        .run   (blank_run),
        .done  (blank_done)
    );

    // Blank_done already opens the first window cycle, so the timer covers the rest
    sgc_timer #(.W(sgc_pkg::TMR_W), .COUNT(sgc_pkg::WIN_CYC - 1)) u_window ( // [R6]
        .clk   (clk),
        .nrst  (nrst),
        .start (blank_done),
        .run   (win_run),
        .done  ()
    );

    sgc_timer #(.W(sgc_pkg::TMR_W), .COUNT(sgc_pkg::OFF_CYC)) u_off ( // [R8]
        .clk   (clk),
        .nrst  (nrst),
        .start (off_start),
        .run   (off_run),
        .done  (off_done)
    );

    // Every command edge restarts the cease interval
    sgc_timer #(.W(sgc_pkg::TMR_W), .COUNT(CEASE_CYC)) u_cease ( // [R16]
        .clk   (clk),
        .nrst  (nrst),
        .start (act),
        .run   (),
        .done  (cease_done)
    );

    // ==========================================================
    // Supply lockout flags
    always_comb begin
        next_uv_ok   = uv_ok;
        next_ov_lock = ov_lock;
        if (vdd_above_uv_hi) begin
            next_uv_ok = 1'b1; // [R2]
        end else if (vdd_below_uv_lo) begin
            next_uv_ok = 1'b0; // [R2]
        end
        if (vdd_above_ov_hi) begin
            next_ov_lock = 1'b1; // [R4]
        end else if (vdd_below_ov_lo) begin
            next_ov_lock = 1'b0; // [R4]
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            uv_ok   <= 1'b0;
            ov_lock <= 1'b0;
        end else begin
            uv_ok   <= next_uv_ok;
            ov_lock <= next_ov_lock;
        end
    end

    // Next sleep value: the entering edge gates nothing, the waking edge is a command
    assign gate_ok = uv_ok && !ov_lock && !next_sleep; // [R3] [R4] [R17]

    // ==========================================================
    // Command pin: mode, cease and sleep burst detection
    assign fall = pulse_q && !pulse_n;
    assign act  = pulse_q != pulse_n;

    always_comb begin
        next_pulse_q = pulse_n;
        next_ext     = ext_mode;
        next_sleep   = sleep_mode;
        next_edge    = edge_cnt;
        next_gap     = (gap_cnt == sgc_pkg::GAP_MAX) ? gap_cnt : gap_cnt + 1'b1;
        if (fall) begin
            next_gap  = '0;
            // Normal PWM edges are far apart, so they never build a burst
            next_edge = (gap_cnt < sgc_pkg::GAP_MAX) ? edge_cnt + 3'h1 : 3'h1;
            if (sleep_mode) begin
                next_sleep = 1'b0; // [R17]
                next_edge  = '0;
            end else if (next_edge == sgc_pkg::SLEEP_EDGES) begin
                next_sleep = 1'b1; // [R17]
                next_edge  = '0;
            end
        end
        if (cease_done && !act) begin
            next_ext = 1'b0; // [R16]
        end
        if (act && vdd_above_reg_off) begin
            next_ext = 1'b1; // [R1]
        end
        if (!uv_ok) begin
            next_ext   = 1'b0; // [R3]
            next_sleep = 1'b0; // [R17]
            next_edge  = '0;
        end
        next_ref_high = next_ext; // [R9]
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pulse_q       <= 1'b1;
            ext_mode      <= 1'b0;
            sleep_mode    <= 1'b0;
            edge_cnt      <= '0;
            gap_cnt       <= sgc_pkg::GAP_MAX;
            peak_ref_high <= 1'b0;
        end else begin
            pulse_q       <= next_pulse_q;
            ext_mode      <= next_ext;
            sleep_mode    <= next_sleep;
            edge_cnt      <= next_edge;
            gap_cnt       <= next_gap;
            peak_ref_high <= next_ref_high;
        end
    end

    // ==========================================================
    // Low-frequency burst counter, idle in external mode
    assign lfo_wrap = (lfo_cnt + LFO_W'(1)) >= lfo_period; // [R12]
    assign burst_ok = pulse_cnt < sgc_pkg::PULSE_MAX;

    always_comb begin
        next_lfo  = lfo_cnt + LFO_W'(1);
        next_pcnt = pulse_cnt;
        if (next_ext || !uv_ok) begin
            next_lfo  = '0; // [R13]
            next_pcnt = '0;
        end else if (lfo_wrap) begin
            next_lfo  = '0; // [R11]
            next_pcnt = '0;
        end else if (on_start && burst_ok) begin
            next_pcnt = pulse_cnt + 5'h1; // [R11]
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lfo_cnt   <= '0;
            pulse_cnt <= '0;
        end else begin
            lfo_cnt   <= next_lfo;
            pulse_cnt <= next_pcnt;
        end
    end

    // ==========================================================
    // Gate latch and sequencing
    // Window comparator only counts inside its window; peak after blanking
    assign win_open = blank_done || win_run; // [R6]
    assign trip = (peak_limit_cmp && !blank_run) || (ccm_window_cmp && win_open); // [R5] [R6] [R7]

    always_comb begin
        next_state = state;
        case (state)
            sgc_pkg::ST_IDLE: begin
                if (gate_ok) begin
                    if (next_ext) begin
                        if (fall) begin
                            next_state = sgc_pkg::ST_ON; // [R15]
                        end
                    end else if (burst_ok) begin
                        next_state = sgc_pkg::ST_ON; // [R2] [R11]
                    end
                end
            end
            sgc_pkg::ST_ON: begin
                if (!gate_ok) begin
                    next_state = sgc_pkg::ST_IDLE; // [R3] [R4]
                end else if (next_ext) begin
                    if (pulse_n || trip) begin
                        next_state = sgc_pkg::ST_IDLE; // [R10] [R15]
                    end
                end else if (trip) begin
                    next_state = sgc_pkg::ST_OFF; // [R7]
                end
            end
            sgc_pkg::ST_OFF: begin
                if (!gate_ok) begin
                    next_state = sgc_pkg::ST_IDLE;
                end else if (next_ext) begin
                    next_state = fall ? sgc_pkg::ST_ON : sgc_pkg::ST_IDLE; // [R15]
                end else if (off_done) begin
                    next_state = burst_ok ? sgc_pkg::ST_ON : sgc_pkg::ST_IDLE; // [R8]
                end
            end
            default: begin
                next_state = sgc_pkg::ST_IDLE;
            end
        endcase
        next_gate = next_state == sgc_pkg::ST_ON;
    end

    assign on_start  = (state != sgc_pkg::ST_ON) && (next_state == sgc_pkg::ST_ON);
    assign off_start = (state != sgc_pkg::ST_OFF) && (next_state == sgc_pkg::ST_OFF);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= sgc_pkg::ST_IDLE;
            gate  <= 1'b0;
        end else begin
            state <= next_state;
            gate  <= next_gate;
        end
    end

    // ==========================================================
    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    uv_rise_a: assert property ($rose(uv_ok) |-> $past(vdd_above_uv_hi)) // [R2]
        else $error("undervoltage flag rose without upper level");
    accept_ext_a: assert property ($rose(ext_mode) |-> $past(vdd_above_reg_off)) // [R1]
        else $error("external mode entered before regulator turn-off");
    uv_low_a: assert property (!uv_ok |=> !gate) // [R3]
        else $error("gate high under undervoltage");
    ov_stop_a: assert property (ov_lock |=> !gate) // [R4]
        else $error("gate high under overvoltage");
    blank_len_a: assert property ($rose(gate) |-> blank_run ##23 blank_run ##1 !blank_run) // [R5]
        else $error("blanking interval wrong length");
    window_len_a: assert property ($fell(blank_run) |-> win_open ##16 win_open ##1 !win_open) // [R6]
        else $error("window interval wrong length");
    trip_end_a: assert property (state == sgc_pkg::ST_ON && trip |=> !gate) // [R7] [R10]
        else $error("comparator trip did not end on-time");
    off_hold_a: assert property (state == sgc_pkg::ST_OFF |-> !gate && (off_run || off_done)) // [R8]
        else $error("gate high or timer idle during off-time");
    off_restart_a: assert property (state == sgc_pkg::ST_OFF && off_done && gate_ok // [R8]
                                    && !next_ext && burst_ok |=> gate)
        else $error("no new on-time after off-time");
    ref_sel_a: assert property (peak_ref_high == ext_mode) // [R9]
        else $error("peak reference disagrees with mode");
    burst_stop_a: assert property (!ext_mode && !act && pulse_cnt == sgc_pkg::PULSE_MAX // [R11]
                                   && state != sgc_pkg::ST_ON |=> !gate)
        else $error("more than sixteen start-up pulses");
    lfo_off_a: assert property (next_ext |=> lfo_cnt == '0 && pulse_cnt == '0) // [R13]
        else $error("oscillator running in external mode");
    ext_low_a: assert property (ext_mode && pulse_n && !cease_done |=> !gate) // [R15]
        else $error("gate high while command input high");
    cease_end_a: assert property (cease_done && !act |=> !ext_mode) // [R16]
        else $error("external mode kept after cease interval");
    sleep_off_a: assert property (sleep_mode |-> !gate) // [R17]
        else $error("gate high in sleep");

endmodule

/* File: dv/sgc_partner.sv */
// Secondary-side controller model that drives the active-low command pin.
// Assumes the bench calls one task at a time, from the clock's rising edge.
module sgc_partner (
    input  wire logic clk,
    output logic      pulse_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // The pin's pull-up keeps it high whenever no command is sent
    initial pulse_n = 1'b1;

    // ==========================================================
    // Command waveforms
    // Low requests the gate on; every level is kept shorter than the
    // cease interval so the device stays externally commanded
    task automatic pwm(input int n, input int lo, input int hi);
        repeat (n) begin
            @(posedge clk);
            pulse_n <= 1'b0;
            repeat (lo) @(posedge clk);
            pulse_n <= 1'b1;
            repeat (hi - 1) @(posedge clk);
        end
    endtask
endmodule

/* File: dv/sgc_gate_ctrl_tb_top.sv */
// Self-checking bench for the start-up gate controller.
// Assumes the partner model in sgc_partner.sv and the shared package.
module sgc_gate_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int CEASE = 2000;
    localparam int LIMIT = 99000;
    localparam int BLANK = sgc_pkg::BLANK_CYC;
    localparam int WIN   = sgc_pkg::WIN_CYC;
    localparam int OFF   = sgc_pkg::OFF_CYC;

    logic                      clk     = 1'b0;
    logic                      nrst    = 1'b0;
    logic                      uv_hi   = 1'b0;
    logic                      uv_lo   = 1'b1;
    logic                      ov_hi   = 1'b0;
    logic                      ov_lo   = 1'b1;
    logic                      reg_off = 1'b0;
    logic                      peak    = 1'b0;
    logic                      ccm     = 1'b0;
    logic [sgc_pkg::LFO_W-1:0] low_freq_osc     = 21'h08ca0;
    logic                      pulse_n;
    logic                      gate;
    logic                      ref_hi;
    logic                      ext;
    logic                      slp;
    logic                      fol     = 1'b0;
    logic                      gl      = 1'b0;
    logic                      pn1     = 1'b1;
    logic                      pn2     = 1'b1;
    int                        errors  = 0;
    int                        n_checks = 0;
    int                        cyc     = 0;
    int                        rises   = 0;
    int                        seed    = 16528;

    always #5 clk = ~clk;

    sgc_gate_ctrl #(.CEASE_CYC(CEASE)) sgc_gate_ctrl_inst (
        .clk               (clk),
        .nrst              (nrst),
        .vdd_above_uv_hi   (uv_hi),
        .vdd_below_uv_lo   (uv_lo),
        .vdd_above_ov_hi   (ov_hi),
        .vdd_below_ov_lo   (ov_lo),
        .vdd_above_reg_off (reg_off),
        .pulse_n           (pulse_n),
        .peak_limit_cmp    (peak),
        .ccm_window_cmp    (ccm),
        .lfo_period        (low_freq_osc),
        .gate              (gate),
        .peak_ref_high     (ref_hi),
        .ext_mode          (ext),
        .sleep_mode        (slp)
    );

    sgc_partner sgc_partner_inst (
        .clk     (clk),
        .pulse_n (pulse_n)
    );

    // ==========================================================
    // Reporting
    task automatic results();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic ok, input string what);
        n_checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask

    // ==========================================================
    // Reference model of one internal on-time, in clock cycles
    function automatic int exp_on(input int pk, input int cw);
        int e;
        e = (pk < BLANK) ? BLANK : pk;
        if (cw <= BLANK + WIN && (cw < BLANK ? BLANK : cw) < e) e = (cw < BLANK) ? BLANK : cw;
        return e;
    endfunction

    // Bounded wait; n reaches max when the gate never took level v
    task automatic wait_gate(input logic v, input int max, output int n);
        n = 0;
        while (gate !== v && n < max) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic trip();
        int t;
        @(posedge clk);
        peak <= 1'b1;
        // A trip cannot land before blanking ends
        wait_gate(1'b0, BLANK + 10, t);
        @(posedge clk);
        peak <= 1'b0;
    endtask

    // Supply lockout, the hysteresis band, then release
    task automatic lockout(input bit ov);
        int t;
        @(posedge clk);
        {ov_hi, ov_lo} <= ov ? 2'b10 : 2'b01;
        {uv_hi, uv_lo} <= ov ? 2'b10 : 2'b01;
        wait_gate(1'b0, 5, t);
        chk(t < 5, "lockout did not stop gate");
        @(posedge clk);
        {ov_hi, ov_lo, uv_lo} <= 3'h0;
        wait_gate(1'b1, 2500, t);
        chk(t == 2500, "gating inside hysteresis band");
        @(posedge clk);
        ov_lo <= 1'b1;
        uv_hi <= 1'b1;
        wait_gate(1'b1, 2500, t);
        chk(t < 2500, "no resume after lockout");
    endtask

    // ==========================================================
    // Monitors: hang limit, gate rises, command following
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            errors++;
            results();
        end
    end

    always @(negedge clk) begin
        if (gate === 1'b1 && gl === 1'b0) rises++;
        gl <= gate;
        pn1 <= pulse_n;
        pn2 <= pn1;
        if (fol && ext === 1'b1 && pulse_n === pn1 && pn1 === pn2)
            chk(gate === !pulse_n && ref_hi === 1'b1, "gate not following command");
    end

    // ==========================================================
    // Main sequence
    initial begin
        int t, n, r, k, pk, cw;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        chk(gate === 1'b0 && ext === 1'b0 && slp === 1'b0, "outputs after reset");
        wait_gate(1'b1, 200, t);
        chk(t == 200, "gate while supply low");
        @(posedge clk);
        uv_hi <= 1'b1;
        uv_lo <= 1'b0;
        // Random trip times; the window slots stay clear of its edges
        for (int i = 0; i < 16; i++) begin
            wait_gate(1'b1, 3000, t);
            if (i > 0) chk(t >= OFF - 3 && t <= OFF + 3, "off time");
            else chk(t <= 4, "no start after supply good");
            r = $random(seed) & 32'h7fffffff;
            k = r % 3;
            pk = (r >> 2) % 100;
            cw = (k == 0) ? (r >> 9) % 16 : (k == 1) ? 28 + (r >> 9) % 10 : 50 + (r >> 9) % 20;
            n = 0;
            while (gate === 1'b1 && n < 300) begin
                @(posedge clk);
                n++;
                peak <= (n >= pk);
                ccm <= (n >= cw);
                @(negedge clk);
            end
            @(posedge clk);
            peak <= 1'b0;
            ccm <= 1'b0;
            chk(n >= exp_on(pk, cw) - 1 && n <= exp_on(pk, cw) + 4, "on time");
            chk(ref_hi === 1'b0, "reference under internal control");
        end
        wait_gate(1'b1, 40000, t);
        chk(t > OFF + 500 && t < 40000, "pulses per oscillator period");
        lockout(1'b1);
        lockout(1'b0);
        trip();
        sgc_partner_inst.pwm(3, 300, 300);
        chk(ext === 1'b0, "command taken while regulator on");
        reg_off <= 1'b1;
        rises = 0;
        fol = 1'b1;
        for (int i = 0; i < 20; i++) begin
            r = $random(seed) & 32'h7fffffff;
            sgc_partner_inst.pwm(1, 250 + r % 300, 250 + (r >> 9) % 300);
        end
        fol = 1'b0;
        chk(rises === 20 && ext === 1'b1, "external pulses lost");
        fork
            sgc_partner_inst.pwm(1, 800, 300);
            begin
                repeat (100) @(posedge clk);
                peak <= 1'b1;
                repeat (5) @(posedge clk);
                peak <= 1'b0;
                repeat (300) @(negedge clk);
                chk(gate === 1'b0 && pulse_n === 1'b0, "gate after trip");
            end
        join
        rises = 0;
        sgc_partner_inst.pwm(1, 300, 300);
        chk(rises === 1, "next command did not re-arm");
        repeat (CEASE + 20) @(posedge clk);
        chk(ext === 1'b0, "cease did not return to start-up");
        wait_gate(1'b1, 3000, t);
        chk(t < 3000 && ref_hi === 1'b0, "internal gating after cease");
        trip();
        sgc_partner_inst.pwm(5, 100, 100);
        rises = 0;
        repeat (CEASE + 500) @(negedge clk);
        chk(slp === 1'b1 && rises === 0, "sleep did not stop gating");
        sgc_partner_inst.pwm(1, 300, 300);
        chk(slp === 1'b0 && rises === 1, "command did not wake");
        sgc_partner_inst.pwm(5, 100, 100);
        chk(slp === 1'b1, "second sleep burst");
        uv_hi <= 1'b0;
        uv_lo <= 1'b1;
        repeat (3) @(negedge clk);
        chk(slp === 1'b0 && gate === 1'b0, "lockout did not end sleep");
        results();
    end
endmodule
